// file: rtl/sarrd_pkg.sv
package sarrd_pkg;

  localparam int MCLK_MHZ = 125;
  localparam int WORD_W   = 16;
  localparam int CNT_W    = 8;
  localparam int LK_CNT_W = 5;

  // analog timing in ns; cycle counts derived at the mclk rate
  localparam int CONV_TIME_NS  = 300;
  localparam int SAMPLE_MIN_NS = 100;
  localparam int TD19_NS       = 40;
  localparam int TD13_NS       = 40;
  localparam int TD12_NS       = 40;

  // least times round up, the pre-end lead is a longest time and rounds down
  localparam int CONV_CYCLES   = (CONV_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int SAMPLE_CYCLES = (SAMPLE_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int TD19_RAW      = (TD19_NS * MCLK_MHZ) / 1000;
  localparam int TD19_CYCLES   = (TD19_RAW < 1) ? 1 : TD19_RAW;
  localparam int TD13_CYCLES   = (TD13_NS * MCLK_MHZ + 999) / 1000;
  localparam int TD12_CYCLES   = (TD12_NS * MCLK_MHZ + 999) / 1000;

  localparam logic [CNT_W-1:0] CONV_LAST    = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] PRE_END_CNT  = CNT_W'(CONV_CYCLES - TD19_CYCLES);
  localparam logic [CNT_W-1:0] SAMPLE_FULL  = CNT_W'(SAMPLE_CYCLES);
  localparam logic [CNT_W-1:0] TD13_CNT     = CNT_W'(TD13_CYCLES);
  localparam logic [CNT_W-1:0] TD12_CNT     = CNT_W'(TD12_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ZERO     = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE      = 8'h01;

  // link clock edges counted from the frame sync rise (edge 0)
  localparam logic [LK_CNT_W-1:0] LK_ZERO        = 5'h00;
  localparam logic [LK_CNT_W-1:0] LK_ONE         = 5'h01;
  localparam logic [LK_CNT_W-1:0] EDGE_BYTE_SYNC = 5'h08;
  localparam logic [LK_CNT_W-1:0] EDGE_MSB       = 5'h02;
  localparam logic [LK_CNT_W-1:0] EDGE_WORD_SYNC = 5'h10;
  localparam logic [LK_CNT_W-1:0] EDGE_LSB       = 5'h11;
  localparam logic [LK_CNT_W-1:0] EDGE_END       = 5'h12;
  localparam logic [LK_CNT_W-1:0] EDGE_DAISY_BB  = 5'h0F;
  localparam logic [LK_CNT_W-1:0] EDGE_CASC_BB   = 5'h13;

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    PH_WAIT   = 3'h1,
    PH_SAMPLE = 3'h2,
    PH_CONV   = 3'h4
  } sarrd_phase_t;

  typedef enum logic [2:0] {
    LK_IDLE  = 3'h1,
    LK_OPEN  = 3'h2,
    LK_FRAME = 3'h4
  } sarrd_link_t;

endpackage : sarrd_pkg

// file: rtl/sarrd_xfer_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sarrd_xfer_if;
  logic tgl_src;    // toggles once per event, source domain
  logic pulse_dst;  // one-cycle pulse, destination domain

  modport tx (output tgl_src);
  modport rx (input tgl_src, output pulse_dst);
endinterface : sarrd_xfer_if
`default_nettype wire

// file: rtl/sarrd_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sarrd_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,  // destination clock
  input  wire logic [W-1:0] d_in,    // asynchronous level
  output logic      [W-1:0] q_out    // synchronised level
);
  logic [W-1:0] meta;

  // no reset: first stage feeds only the second
  always_ff @(posedge clk_in) begin
    meta  <= d_in;
    q_out <= meta;
  end
endmodule : sarrd_sync2
`default_nettype wire

// file: rtl/sarrd_tgl_rx.sv
`timescale 1ns/1ns
`default_nettype none
module sarrd_tgl_rx (
  input  wire logic clk_in,  // destination clock
  input  wire logic rst_in,  // destination-domain reset
  sarrd_xfer_if.rx  xf       // toggle in, pulse out
);
  logic meta;
  logic stage;
  logic last;

  always_ff @(posedge clk_in) begin
    meta  <= xf.tgl_src;
    stage <= meta;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last         <= 1'b0;
      xf.pulse_dst <= 1'b0;
    end else begin
      last         <= stage;
      xf.pulse_dst <= stage ^ last;
    end
  end
endmodule : sarrd_tgl_rx
`default_nettype wire

// file: rtl/sarrd_top.sv
// Contract
// - convert-start falling ends sampling and begins conversion
// - conversion busy output stays high throughout a running conversion
// - every conversion lasts the same fixed number of cycles
// - convert-start falling during conversion aborts it; later reads are invalid
// - result valid only after full sample then full conversion
// - read falling with chip select low in wait or sample starts a read
// - read start enables sync and data drivers and raises bus busy
// - word framing: sync period is 16 link clocks
// - byte framing: sync period 8, bit nine from top on edge 10
// - count from first falling edge after sync rise; MSB on edge 2
// - next sync rise on edge 16, LSB on edge 17
// - chip select high mid-read tri-states outputs until next read start
// - wait/sample read: sync starts low, rises fixed delay after read fall
// - read requested before pre-end point starts at that point
// - end-of-conversion read: sync rises fixed delay after conversion end
// - LSB on edge 17, data and sync tri-stated on edge 18
// - daisy topology: bus busy falls shortly before final sync rise
// - convert-start rising samples when waiting, else right after conversion
// - cascade topology: bus busy falls after outputs are tri-stated
// - bus busy is low after power-up
`timescale 1ns/1ns
`default_nettype none
module sarrd_top
  import sarrd_pkg::*;
(
  input  wire logic              mclk_in,                  // control clock, 125 MHz
  input  wire logic              rst_in,                   // synchronous reset, active high
  input  wire logic              link_clk_in,              // serial link clock
  input  wire logic              convert_start_n_cmos_in,  // convert start, active low
  input  wire logic              convert_start_n_diff_in,  // convert start, active low
  input  wire logic              read_n_in,                // read request, active low
  input  wire logic              chip_select_n_in,         // chip select, active low
  input  wire logic              byte_mode_in,             // 1: byte framing
  input  wire logic              cascade_mode_in,          // 1: cascade, 0: daisy chain
  input  wire logic [WORD_W-1:0] sar_result_in,            // converter result at conversion end
  output logic                   conv_busy_out,            // conversion in progress
  output logic                   result_valid_out,         // held result is valid
  output logic                   bus_busy_out,             // link occupied
  output logic                   serial_out,               // serial data
  output logic                   serial_oe_out,            // serial data driver enable
  output logic                   frame_sync_out,           // frame sync
  output logic                   frame_sync_oe_out         // frame sync driver enable
);

  // ---------------- control domain ----------------
  logic [3:0]        pins_sync;
  logic              cvst_n;
  logic              rd_n;
  logic              cs_n;
  logic              cvst_prev;
  logic              rd_prev;
  logic              cvst_fall;
  logic              cvst_rise;
  logic              rd_fall;
  sarrd_phase_t      phase;
  logic [CNT_W-1:0]  conv_cnt;
  logic [CNT_W-1:0]  samp_cnt;
  logic              sample_ok;
  logic              conv_clean;
  logic              sample_pend;
  logic              rd_armed;
  logic              conv_end;
  logic              at_pre_end;
  logic              start_now;
  logic              eoc_read;
  logic              go_pend;
  logic [CNT_W-1:0]  go_cnt;
  logic [WORD_W-1:0] result;

  sarrd_xfer_if start_xf ();
  sarrd_xfer_if go_xf ();

  sarrd_sync2 #(.W(4)) u_pin_sync (
    .clk_in (mclk_in),
    .d_in   ({convert_start_n_cmos_in, convert_start_n_diff_in, read_n_in,
              chip_select_n_in}),
    .q_out  (pins_sync)
  );

  // the two start pins act alike: either one low means low
  assign cvst_n    = pins_sync[3] & pins_sync[2];
  assign rd_n      = pins_sync[1];
  assign cs_n      = pins_sync[0];
  assign cvst_fall = cvst_prev & ~cvst_n;
  assign cvst_rise = ~cvst_prev & cvst_n;
  assign rd_fall   = rd_prev & ~rd_n;
  assign conv_end  = (phase == PH_CONV) && (conv_cnt == CONV_LAST) && !cvst_fall;
  assign at_pre_end = (phase == PH_CONV) && (conv_cnt == PRE_END_CNT) && !cvst_fall;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cvst_prev <= 1'b1;
      rd_prev   <= 1'b1;
    end else begin
      cvst_prev <= cvst_n;
      rd_prev   <= rd_n;
    end
  end

  // sample / convert sequencer
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      phase       <= PH_WAIT;
      conv_cnt    <= CNT_ZERO;
      sample_pend <= 1'b0;
      conv_clean  <= 1'b0;
    end else begin
      case (phase)
        PH_WAIT: begin
          if (cvst_fall) begin
            phase      <= PH_CONV;
            conv_cnt   <= CNT_ZERO;
            conv_clean <= 1'b0;
          end else if (cvst_rise) begin
            phase <= PH_SAMPLE;
          end
        end
        PH_SAMPLE: begin
          if (cvst_fall) begin
            phase      <= PH_CONV;
            conv_cnt   <= CNT_ZERO;
            // the edge that ends sampling closes its last cycle as well
            conv_clean <= sample_ok || (samp_cnt + CNT_ONE == SAMPLE_FULL);
          end
        end
        PH_CONV: begin
          if (cvst_fall) begin
            // abort: the converter is left without a usable word
            phase       <= PH_WAIT;
            sample_pend <= 1'b0;
            conv_clean  <= 1'b0;
          end else if (conv_cnt == CONV_LAST) begin
            // fixed length, only an abort shortens it and nothing stretches it
            sample_pend <= 1'b0;
            phase       <= (sample_pend || cvst_rise) ? PH_SAMPLE : PH_WAIT;
          end else begin
            conv_cnt <= conv_cnt + CNT_ONE;
            if (cvst_rise) begin
              sample_pend <= 1'b1;
            end
          end
        end
        default: begin
          phase <= PH_WAIT;
        end
      endcase
    end
  end

  // track the length of the current sample phase
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      samp_cnt  <= CNT_ZERO;
      sample_ok <= 1'b0;
    end else if (phase != PH_SAMPLE) begin
      samp_cnt  <= CNT_ZERO;
      sample_ok <= 1'b0;
    end else if (samp_cnt != SAMPLE_FULL) begin
      samp_cnt  <= samp_cnt + CNT_ONE;
      sample_ok <= (samp_cnt + CNT_ONE) == SAMPLE_FULL;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      conv_busy_out <= 1'b0;
    end else begin
      conv_busy_out <= (phase == PH_CONV) ? !(cvst_fall || conv_cnt == CONV_LAST)
                                          : cvst_fall && phase != PH_CONV;
    end
  end

  // result is held for the link; the word is stable long before go is sent
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      result           <= WORD_RESET;
      result_valid_out <= 1'b0;
    end else if (phase == PH_CONV && cvst_fall) begin
      result_valid_out <= 1'b0;
    end else if (conv_end) begin
      result           <= sar_result_in;
      result_valid_out <= conv_clean;
    end
  end

  // read request caught during conversion, honoured at the pre-end point
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_armed <= 1'b0;
    end else if (phase != PH_CONV || at_pre_end || cvst_fall) begin
      rd_armed <= 1'b0;
    end else if (rd_fall && !cs_n) begin
      rd_armed <= 1'b1;
    end
  end

  assign start_now = (rd_fall && !cs_n && (phase == PH_WAIT || phase == PH_SAMPLE))
                   || (at_pre_end && !cs_n && (rd_armed || !rd_n));

  // start event opens the link now; go event raises sync after the lead delay
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      start_xf.tgl_src <= 1'b0;
      go_xf.tgl_src    <= 1'b0;
      go_pend          <= 1'b0;
      go_cnt           <= CNT_ZERO;
      eoc_read         <= 1'b0;
    end else begin
      if (start_now) begin
        start_xf.tgl_src <= ~start_xf.tgl_src;
      end
      if (start_now && !at_pre_end) begin
        go_pend  <= 1'b1;
        go_cnt   <= TD13_CNT;
        eoc_read <= 1'b0;
      end else if (start_now) begin
        eoc_read <= 1'b1;
        go_pend  <= 1'b0;
      end else if (eoc_read && conv_end) begin
        eoc_read <= 1'b0;
        go_pend  <= 1'b1;
        go_cnt   <= TD12_CNT;
      end else if (eoc_read && phase != PH_CONV) begin
        eoc_read <= 1'b0;
      end else if (go_pend) begin
        if (go_cnt <= CNT_ONE) begin
          go_pend       <= 1'b0;
          go_xf.tgl_src <= ~go_xf.tgl_src;
        end else begin
          go_cnt <= go_cnt - CNT_ONE;
        end
      end
    end
  end

  // ---------------- link domain ----------------
  logic [3:0]            lk_sync;
  logic                  lk_rst;
  logic                  lk_cs_n;
  logic                  lk_byte;
  logic                  lk_casc;
  sarrd_link_t           lk_state;
  logic [LK_CNT_W-1:0]   edge_cnt;
  logic [LK_CNT_W-1:0]   next_edge;
  logic [WORD_W-1:0]     shreg;

  function automatic logic sync_edge(input logic [LK_CNT_W-1:0] n, input logic bytes);
    sync_edge = (n == LK_ZERO) || (n == EDGE_WORD_SYNC) || (bytes && n == EDGE_BYTE_SYNC);
  endfunction : sync_edge

  sarrd_sync2 #(.W(4)) u_lk_sync (
    .clk_in (link_clk_in),
    .d_in   ({rst_in, chip_select_n_in, byte_mode_in, cascade_mode_in}),
    .q_out  (lk_sync)
  );

  assign lk_rst    = lk_sync[3];
  assign lk_cs_n   = lk_sync[2];
  assign lk_byte   = lk_sync[1];
  assign lk_casc   = lk_sync[0];
  assign next_edge = edge_cnt + LK_ONE;

  sarrd_tgl_rx u_start_rx (
    .clk_in (link_clk_in),
    .rst_in (lk_rst),
    .xf     (start_xf)
  );

  sarrd_tgl_rx u_go_rx (
    .clk_in (link_clk_in),
    .rst_in (lk_rst),
    .xf     (go_xf)
  );

  // edges are counted from the sync-rise edge; the next rising edge after it is count one
  always_ff @(posedge link_clk_in) begin
    if (lk_rst) begin
      lk_state          <= LK_IDLE;
      edge_cnt          <= LK_ZERO;
      shreg             <= WORD_RESET;
      serial_out        <= 1'b0;
      serial_oe_out     <= 1'b0;
      frame_sync_out    <= 1'b0;
      frame_sync_oe_out <= 1'b0;
      bus_busy_out      <= 1'b0;
    end else if (lk_state != LK_IDLE && lk_cs_n) begin
      // stays off until a fresh start event
      lk_state          <= LK_IDLE;
      serial_oe_out     <= 1'b0;
      frame_sync_oe_out <= 1'b0;
      frame_sync_out    <= 1'b0;
      bus_busy_out      <= 1'b0;
    end else begin
      case (lk_state)
        LK_IDLE: begin
          if (start_xf.pulse_dst) begin
            lk_state          <= LK_OPEN;
            serial_oe_out     <= 1'b1;
            frame_sync_oe_out <= 1'b1;
            frame_sync_out    <= 1'b0;
            serial_out        <= 1'b0;
            bus_busy_out      <= 1'b1;
          end
        end
        LK_OPEN: begin
          if (go_xf.pulse_dst) begin
            lk_state       <= LK_FRAME;
            edge_cnt       <= LK_ZERO;
            shreg          <= result;
            frame_sync_out <= 1'b1;
          end
        end
        LK_FRAME: begin
          edge_cnt       <= next_edge;
          frame_sync_out <= (next_edge <= EDGE_WORD_SYNC) && sync_edge(next_edge, lk_byte);
          if (next_edge >= EDGE_MSB && next_edge <= EDGE_LSB) begin
            serial_out <= shreg[WORD_W-1];
            shreg      <= {shreg[WORD_W-2:0], 1'b0};
          end
          if (next_edge == EDGE_END) begin
            serial_oe_out     <= 1'b0;
            frame_sync_oe_out <= 1'b0;
            serial_out        <= 1'b0;
          end
          if (!lk_casc && next_edge == EDGE_DAISY_BB) begin
            bus_busy_out <= 1'b0;
          end
          if (next_edge == EDGE_CASC_BB) begin
            bus_busy_out <= 1'b0;
            lk_state     <= LK_IDLE;
            edge_cnt     <= LK_ZERO;
          end
        end
        default: begin
          lk_state <= LK_IDLE;
        end
      endcase
    end
  end

endmodule : sarrd_top
`default_nettype wire

// file: tb/sarrd_props.sv
`timescale 1ns/1ns
`default_nettype none
module sarrd_props
  import sarrd_pkg::*;
(
  input wire logic mclk_in,            // control clock
  input wire logic rst_in,             // reset
  input wire logic link_clk_in,        // link clock
  input wire logic chip_select_n_in,   // chip select
  input wire logic byte_mode_in,       // byte framing
  input wire logic cascade_mode_in,    // topology
  input wire logic conv_busy_out,      // converting
  input wire logic result_valid_out,   // result valid
  input wire logic bus_busy_out,       // link occupied
  input wire logic serial_oe_out,      // data enable
  input wire logic frame_sync_out,     // frame sync
  input wire logic frame_sync_oe_out   // sync enable
);
  logic [7:0] busy_cnt;

  // length of the current busy run, read back when busy falls
  always_ff @(posedge mclk_in) begin
    if (rst_in || !conv_busy_out) busy_cnt <= 8'h00;
    else busy_cnt <= busy_cnt + 8'h01;
  end

  a_busy_bounded: assert property (@(posedge mclk_in) disable iff (rst_in) busy_cnt <= CONV_CYCLES)
    else $error("busy held past the conversion time");
  a_conv_fixed_len: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(conv_busy_out) && result_valid_out |-> busy_cnt == CONV_CYCLES) else $error("conversion length off");
  a_abort_invalid: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(conv_busy_out) && busy_cnt < CONV_CYCLES |-> !result_valid_out) else $error("aborted result valid");
  a_reset_idle: assert property (@(posedge mclk_in) rst_in [*2] |-> !conv_busy_out && !result_valid_out)
    else $error("control outputs active in reset");
  a_reset_quiet: assert property (@(posedge link_clk_in) rst_in [*8]
    |-> !serial_oe_out && !frame_sync_oe_out && !bus_busy_out) else $error("link outputs active in reset");
  a_open_together: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $rose(serial_oe_out) |-> frame_sync_oe_out && bus_busy_out && !frame_sync_out) else $error("read open wrong");
  a_word_period: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $rose(frame_sync_out) && !byte_mode_in |-> ##1 (!frame_sync_out) [*8] ##8 (frame_sync_out || !frame_sync_oe_out))
    else $error("word sync period wrong");
  a_byte_period: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $rose(frame_sync_out) && byte_mode_in |-> ##8 (frame_sync_out || !frame_sync_oe_out))
    else $error("byte sync period wrong");
  a_tail_release: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $fell(serial_oe_out) && !chip_select_n_in |-> $past(frame_sync_out, 2)) else $error("release not on edge 18");
  a_cs_release: assert property (@(posedge link_clk_in) disable iff (rst_in)
    chip_select_n_in [*5] |-> !serial_oe_out && !frame_sync_oe_out) else $error("driving while deselected");
  a_daisy_lead: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $fell(bus_busy_out) && !cascade_mode_in && !chip_select_n_in |-> ##1 $rose(frame_sync_out))
    else $error("daisy busy fall misplaced");
  a_cascade_lag: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $fell(bus_busy_out) && cascade_mode_in && !chip_select_n_in |-> !serial_oe_out && !$past(serial_oe_out))
    else $error("cascade busy fell before release");

  c_word: cover property (@(posedge link_clk_in) $rose(frame_sync_out) && !byte_mode_in);
  c_byte: cover property (@(posedge link_clk_in) $rose(frame_sync_out) && byte_mode_in);
  c_abort: cover property (@(posedge mclk_in) $fell(conv_busy_out) && busy_cnt < CONV_CYCLES);
  c_cascade: cover property (@(posedge link_clk_in) $fell(bus_busy_out) && cascade_mode_in);
endmodule : sarrd_props

bind sarrd_top sarrd_props sarrd_props_i (
  .mclk_in(mclk_in), .rst_in(rst_in), .link_clk_in(link_clk_in), .chip_select_n_in(chip_select_n_in),
  .byte_mode_in(byte_mode_in), .cascade_mode_in(cascade_mode_in), .conv_busy_out(conv_busy_out),
  .result_valid_out(result_valid_out), .bus_busy_out(bus_busy_out), .serial_oe_out(serial_oe_out),
  .frame_sync_out(frame_sync_out), .frame_sync_oe_out(frame_sync_oe_out));
`default_nettype wire

// file: tb/sarrd_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module sarrd_rx_model (
  input  wire logic        link_clk_in,  // link clock
  input  wire logic        serial_in,    // serial data
  input  wire logic        data_oe_in,   // data enable
  input  wire logic        sync_in,      // frame sync
  input  wire logic        sync_oe_in,   // sync enable
  input  wire logic        byte_mode_in, // byte framing
  output logic      [15:0] word_out,     // last word
  output logic      [7:0]  upper_out,    // last upper byte
  output var int           count_out     // words taken
);
  logic [15:0] shreg;
  int          edge_n;

  initial begin
    shreg = 16'h0000;
    word_out = 16'h0000;
    upper_out = 8'h00;
    count_out = 0;
    edge_n = -1;
  end

  always @(negedge link_clk_in) begin
    if (data_oe_in) shreg <= {shreg[14:0], serial_in};
  end

  // edge_n holds the rising-edge number counted from the sync rise
  always @(posedge link_clk_in) begin
    if (!sync_oe_in) edge_n <= -1;
    else if (edge_n < 0 && sync_in) edge_n <= 1;
    else if (edge_n >= 0) edge_n <= edge_n + 1;
    if (edge_n == 9 && byte_mode_in) upper_out <= shreg[7:0];
    if (edge_n == 17 && sync_oe_in) begin
      word_out <= shreg;
      count_out <= count_out + 1;
      edge_n <= -1;
    end
  end
endmodule : sarrd_rx_model
`default_nettype wire

// file: tb/tb_sar_adc_convert_and_serial_readout.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sar_adc_convert_and_serial_readout;
  import sarrd_pkg::*;
  logic        mclk, link_clk, rst, cmos_n, diff_n, read_n, cs_n, byte_mode, cascade;
  logic        conv_busy, res_valid, bus_busy, sdata, sdata_oe, fsync, fsync_oe;
  logic [15:0] sar, held, rx_word;
  logic [7:0]  rx_upper;
  int          rx_count, num_errors, tests_run;
  logic [15:0] exp_q[$];

  sarrd_top sarrd_top_i (
    .mclk_in(mclk), .rst_in(rst), .link_clk_in(link_clk), .convert_start_n_cmos_in(cmos_n),
    .convert_start_n_diff_in(diff_n), .read_n_in(read_n), .chip_select_n_in(cs_n), .byte_mode_in(byte_mode),
    .cascade_mode_in(cascade), .sar_result_in(sar), .conv_busy_out(conv_busy), .result_valid_out(res_valid),
    .bus_busy_out(bus_busy), .serial_out(sdata), .serial_oe_out(sdata_oe), .frame_sync_out(fsync),
    .frame_sync_oe_out(fsync_oe));

  sarrd_rx_model sarrd_rx_model_i (
    .link_clk_in(link_clk), .serial_in(sdata), .data_oe_in(sdata_oe), .sync_in(fsync), .sync_oe_in(fsync_oe),
    .byte_mode_in(byte_mode), .word_out(rx_word), .upper_out(rx_upper), .count_out(rx_count));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    link_clk = 1'b0;
    #2;
    forever #3 link_clk = ~link_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // full conversion loads sar into the held word, an abort does not
  task automatic convert(input int samp, input bit use_diff, input bit abort_it);
    int n;
    n = 0;
    cmos_n = 1'b1;
    diff_n = 1'b1;
    sar = 16'($urandom);
    repeat (samp) @(negedge mclk);
    if (use_diff) diff_n = 1'b0;
    else cmos_n = 1'b0;
    while (conv_busy !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    if (abort_it) begin
      repeat (10) @(negedge mclk);
      cmos_n = 1'b1;
      repeat (4) @(negedge mclk);
      cmos_n = 1'b0;
    end
    while (conv_busy === 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (!abort_it) check(16'(n), 16'(CONV_CYCLES));
    check({15'h0, res_valid}, {15'h0, !abort_it && samp >= SAMPLE_CYCLES});
    if (!abort_it) held = sar;
  endtask : convert

  task automatic wait_rx(input bit exp_frame);
    int          c0;
    int          n;
    logic [15:0] w;
    c0 = rx_count;
    n = 0;
    while (rx_count == c0 && n < 120) begin
      @(negedge mclk);
      n++;
    end
    check(16'(rx_count - c0), {15'h0, exp_frame});
    if (exp_frame) begin
      w = exp_q.pop_front();
      check(rx_word, w);
      if (byte_mode) check({8'h00, rx_upper}, {8'h00, w[15:8]});
    end
    repeat (6) @(negedge mclk);
  endtask : wait_rx

  task automatic do_read(input bit exp_frame);
    read_n = 1'b1;
    repeat (2) @(negedge mclk);
    read_n = 1'b0;
    if (exp_frame) exp_q.push_back(held);
    wait_rx(exp_frame);
    read_n = 1'b1;
  endtask : do_read

  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    num_errors = 0;
    tests_run = 0;
    rst = 1'b1;
    {cmos_n, diff_n, read_n, cs_n, byte_mode, cascade} = 6'b111100;
    sar = 16'h0000;
    held = 16'h0000;
    void'($urandom(32'h63842325));
    repeat (16) @(negedge mclk);
    check({12'h000, conv_busy, bus_busy, sdata_oe, fsync_oe}, 16'h0000);
    rst = 1'b0;
    repeat (8) @(negedge mclk);
    cs_n = 1'b0;
    // start pins idle high: conversion straight from wait, no sample, invalid
    convert(1, 1'b0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      byte_mode = m[0];
      cascade = m[1];
      convert(20, m[1], 1'b0);
      do_read(1'b1);
      $display("test wait-phase read %0d done", m);
    end
    convert(SAMPLE_CYCLES - 1, 1'b0, 1'b0);
    convert(SAMPLE_CYCLES, 1'b1, 1'b0);
    convert(20, 1'b0, 1'b1);
    $display("test sample length and abort done");
    read_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      cascade = k[0];
      convert(20, k[0], 1'b0);
      exp_q.push_back(sar);
      wait_rx(1'b1);
    end
    read_n = 1'b1;
    // short read pulse mid-conversion is armed and served at the pre-end point
    fork
      convert(20, 1'b0, 1'b0);
      begin
        repeat (40) @(negedge mclk);
        read_n = 1'b0;
        repeat (4) @(negedge mclk);
        read_n = 1'b1;
      end
    join
    exp_q.push_back(sar);
    wait_rx(1'b1);
    $display("test end-of-conversion read done");
    repeat (2) @(negedge mclk);
    read_n = 1'b0;
    repeat (14) @(negedge mclk);
    cs_n = 1'b1;
    repeat (10) @(negedge mclk);
    check({14'h0000, sdata_oe, fsync_oe}, 16'h0000);
    cs_n = 1'b0;
    wait_rx(1'b0);
    cs_n = 1'b1;
    do_read(1'b0);
    cs_n = 1'b0;
    do_read(1'b1);
    $display("test chip select abort done");
    print_verdict();
  end
endmodule : tb_sar_adc_convert_and_serial_readout
`default_nettype wire
